// File: src/amd_decoder.sv
// Address map decoder: region selects, register page and read data path
// Operation
// - Decode a 16-bit byte address over a 64K space of memory and registers.
// - Provide 128-byte register page, 128-byte RAM, 128-byte EEPROM, 1.5K program.
// - Stack lives inside RAM only at 0C0h to 0FFh, 64 bytes.
// - Top addresses select reset and interrupt vectors.
// - First program sector size comes from the option byte.
// - Port data reads give latch for outputs, pin level for inputs.
// - Reset loads port A option 40h, port B data with the low PB_W bits of E0h (00h at the default 5 pins), port A data 00h.
// - Lite timer status, capture and serial data have undefined reset contents.
// - Capture, counter halves and converter result are read only.
module amd_decoder #(
   parameter int PB_W = amd_pkg::PB_PINS
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // CPU bus
   input wire logic [15:0] busAddr,
   input wire logic busRead,
   input wire logic busWrite,
   input wire logic [7:0] busWdata,
   output logic [7:0] busRdata,
   // Memory side
   output logic memSelRam,
   output logic memSelStack,
   output logic memSelEeprom,
   output logic memSelProg,
   output logic memSelSector0,
   output logic memSelVector,
   output logic memWrite,
   output logic [10:0] memIndex,
   input wire logic [7:0] memRdata,
   // Option byte
   input wire logic [1:0] optSector0Size,
   // Port A pins
   input wire logic [7:0] portAPinIn,
   output logic [7:0] portAPinOut,
   output logic [7:0] portAPinOe,
   output logic [7:0] portAOption,
   // Port B pins
   input wire logic [PB_W-1:0] portBPinIn,
   output logic [PB_W-1:0] portBPinOut,
   output logic [PB_W-1:0] portBPinOe,
   output logic [7:0] portBOption,
   // Peripheral status sources
   input wire logic [7:0] ltCaptureIn,
   input wire logic [7:0] countHighIn,
   input wire logic [7:0] countLowIn,
   input wire logic [7:0] convResultIn,
   // Peripheral control registers
   output logic [amd_pkg::NUM_RW*8-1:0] rwRegs,
   output logic [amd_pkg::NUM_RW-1:0] rwWriteStb
);

   if (PB_W < 1 || PB_W > 8) begin : gBadPb
      $error("amd_decoder PB_W must be 1 to 8");
   end

   logic selReg;
   logic [1:0] sect0OptFf, nxtSect0Opt;
   logic [6:0] regOff;
   logic regWr;
   logic [7:0] paRead, pbRead;
   logic [7:0] regValue, readValue;
   logic regHit;
   logic [7:0] rdataFf, nxtRdata;

   assign regOff = busAddr[6:0];
   assign regWr = busWrite && selReg;

   // Option byte is sampled while reset is held and kept afterwards
   always_comb begin
      nxtSect0Opt = rst_n ? sect0OptFf : optSector0Size;
   end

   always_ff @(posedge core_clk) begin
      sect0OptFf <= nxtSect0Opt;
   end

   // Region decode of the live bus address
   amd_region_decode uDecode (
      .addr(busAddr),
      .sect0Opt(sect0OptFf),
      .selReg(selReg),
      .selRam(memSelRam),
      .selStack(memSelStack),
      .selEeprom(memSelEeprom),
      .selProg(memSelProg),
      .selSector0(memSelSector0),
      .selVector(memSelVector),
      .memIndex(memIndex)
   );

   // Memory writes pass through; program writes are screened by the flash controller
   assign memWrite = busWrite && (memSelRam || memSelEeprom || memSelProg);

   // Port A with its reset values
   amd_port #(
      .WIDTH(amd_pkg::PA_PINS),
      .DATA_RST(amd_pkg::RST_PA_DATA),
      .OPT_RST(amd_pkg::RST_PA_OPT)
   ) uPortA (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .wrData(regWr && regOff == amd_pkg::OFF_PA_DATA),
      .wrDir(regWr && regOff == amd_pkg::OFF_PA_DIR),
      .wrOpt(regWr && regOff == amd_pkg::OFF_PA_OPT),
      .wdata(busWdata),
      .pinIn(portAPinIn),
      .pinOut(portAPinOut),
      .pinOe(portAPinOe),
      .option(portAOption),
      .readData(paRead)
   );

   // Port B; only the bonded pins carry storage
   amd_port #(
      .WIDTH(PB_W),
      .DATA_RST(amd_pkg::RST_PB_DATA),
      .OPT_RST(amd_pkg::RST_ZERO)
   ) uPortB (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .wrData(regWr && regOff == amd_pkg::OFF_PB_DATA),
      .wrDir(regWr && regOff == amd_pkg::OFF_PB_DIR),
      .wrOpt(regWr && regOff == amd_pkg::OFF_PB_OPT),
      .wdata(busWdata),
      .pinIn(portBPinIn),
      .pinOut(portBPinOut),
      .pinOe(portBPinOe),
      .option(portBOption),
      .readData(pbRead)
   );

   // Plain control registers, one per table entry
   for (genvar g = 0; g < amd_pkg::NUM_RW; g++) begin : gRw
      logic [7:0] valFf, nxtVal;
      logic hit;
      assign hit = regWr && (regOff == amd_pkg::RW_OFF[g]);
      always_comb begin
         nxtVal = hit ? busWdata : valFf;
      end
      if (amd_pkg::RW_DEFINED[g]) begin : gRst
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               valFf <= amd_pkg::RST_ZERO;
            end else begin
               valFf <= nxtVal;
            end
         end
      end else begin : gNoRst
         // No reset: saves a mux and matches the undefined power-up contents
         always_ff @(posedge core_clk) begin
            valFf <= nxtVal;
         end
      end
      assign rwRegs[g*8 +: 8] = valFf;
      assign rwWriteStb[g] = hit;
   end

   // Register page read mux; read-only sources have no write path at all
   always_comb begin
      regValue = amd_pkg::RST_ZERO;
      regHit = 1'b1;
      unique case (regOff)
         amd_pkg::OFF_PA_DATA: regValue = paRead;
         amd_pkg::OFF_PA_DIR: regValue = portAPinOe;
         amd_pkg::OFF_PA_OPT: regValue = portAOption;
         amd_pkg::OFF_PB_DATA: regValue = pbRead;
         amd_pkg::OFF_PB_DIR: regValue = 8'(portBPinOe);
         amd_pkg::OFF_PB_OPT: regValue = portBOption;
         amd_pkg::OFF_LT_CAPTURE: regValue = ltCaptureIn;
         amd_pkg::OFF_CNT_HIGH: regValue = countHighIn;
         amd_pkg::OFF_CNT_LOW: regValue = countLowIn;
         amd_pkg::OFF_CONV_RESULT: regValue = convResultIn;
         default: begin
            regHit = 1'b0;
            for (int k = 0; k < amd_pkg::NUM_RW; k++) begin
               if (regOff == amd_pkg::RW_OFF[k]) begin
                  regValue = rwRegs[k*8 +: 8];
                  regHit = 1'b1;
               end
            end
         end
      endcase
   end

   // Read source by region; reserved holes read zero
   always_comb begin
      readValue = amd_pkg::RST_ZERO;
      if (selReg) begin
         readValue = regHit ? regValue : amd_pkg::RST_ZERO;
      end else if (memSelRam || memSelEeprom || memSelProg) begin
         readValue = memRdata;
      end
   end

   // Read data is registered and holds until the next read
   always_comb begin
      nxtRdata = busRead ? readValue : rdataFf;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdataFf <= amd_pkg::RST_ZERO;
      end else begin
         rdataFf <= nxtRdata;
      end
   end

   assign busRdata = rdataFf;

   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // Sector end, one past its last byte; 17 bits, as the full size reaches 10000h and would wrap to zero
   logic [16:0] sect0Limit;
   always_comb begin
      unique case (sect0OptFf)
         amd_pkg::SECT0_OPT_SMALL: sect0Limit = 17'(amd_pkg::PROG_BASE) + 17'(amd_pkg::SECT0_SIZE_SMALL);
         amd_pkg::SECT0_OPT_MID: sect0Limit = 17'(amd_pkg::PROG_BASE) + 17'(amd_pkg::SECT0_SIZE_MID);
         default: sect0Limit = 17'(amd_pkg::PROG_BASE) + 17'(amd_pkg::SECT0_SIZE_FULL);
      endcase
   end

   sequence sReadRo;
      busRead && selReg && (regOff == amd_pkg::OFF_CNT_HIGH);
   endsequence

   sequence sWriteThenRead;
      (busWrite && selReg && regOff == amd_pkg::OFF_CNT_HIGH && busWdata != countHighIn) ##[1:2] sReadRo;
   endsequence

   // Write to an offset with neither storage nor a read-only source
   sequence sReservedWrite;
      busWrite && selReg && !regHit;
   endsequence

   a_space_onehot: assert property ($onehot0({selReg, memSelRam, memSelEeprom, memSelProg})
      && (selReg == (busAddr <= amd_pkg::REG_LAST)))
      else $error("region selects overlap or register page misdecoded");

   a_ram_index: assert property (memSelRam |-> memIndex == 11'(busAddr - amd_pkg::RAM_BASE)
      && memIndex < 11'h080)
      else $error("RAM index out of its 128-byte window");

   a_stack_window: assert property (memSelStack |-> memSelRam && busAddr >= amd_pkg::STACK_BASE)
      else $error("stack select outside 0C0h-0FFh");

   a_vector_top: assert property ((busAddr >= amd_pkg::VEC_BASE) |-> memSelVector && memSelProg)
      else $error("top addresses did not select vectors");

   a_sector_option: assert property (memSelProg |-> memSelSector0 == ({1'b0, busAddr} < sect0Limit))
      else $error("first sector select disagrees with option size");

   a_port_readback: assert property (busRead && selReg && regOff == amd_pkg::OFF_PA_DATA
      |=> (busRdata & $past(portAPinOe)) == ($past(portAPinOut) & $past(portAPinOe)))
      else $error("port A output bits did not return latch value");

   a_reset_values: assert property ($rose(rst_n) |-> portAOption == amd_pkg::RST_PA_OPT
      && portBPinOut == amd_pkg::RST_PB_DATA[PB_W-1:0] && portAPinOut == amd_pkg::RST_PA_DATA)
      else $error("port reset values wrong");

   a_ro_ignore: assert property (sWriteThenRead |=> busRdata == $past(countHighIn))
      else $error("write altered a read-only counter register");

   a_reserved_zero: assert property (busRead && selReg && !regHit |=> busRdata == amd_pkg::RST_ZERO)
      else $error("reserved register read not zero");

   // Storage guards: writes land only where the map gives storage; then port B readback
   a_reserved_quiet: assert property (sReservedWrite |-> rwWriteStb == '0 && !memWrite)
      else $error("reserved register write reached storage");

   a_ro_no_strobe: assert property (busWrite && selReg && (regOff == amd_pkg::OFF_CNT_LOW
      || regOff == amd_pkg::OFF_LT_CAPTURE || regOff == amd_pkg::OFF_CONV_RESULT) |-> rwWriteStb == '0)
      else $error("write to a read-only register strobed a control register");

   a_strobe_write: assert property (rwWriteStb != '0 |-> busWrite && selReg && $onehot(rwWriteStb))
      else $error("control register strobe without a register page write");

   a_mem_write_gate: assert property (memWrite |-> busWrite && !selReg)
      else $error("memory write raised outside a memory region");

   a_port_b_readback: assert property (busRead && selReg && regOff == amd_pkg::OFF_PB_DATA
      |=> (busRdata & 8'($past(portBPinOe))) == (8'($past(portBPinOut)) & 8'($past(portBPinOe))))
      else $error("port B output bits did not return latch value");

   // Read data timing, state kept across the run, and the values reset clears
   a_rdata_hold: assert property (!$past(busRead) |-> $stable(busRdata))
      else $error("read data changed without a read");

   a_option_hold: assert property ($stable(sect0OptFf))
      else $error("sector option changed outside reset");

   a_reset_clear: assert property ($rose(rst_n) |-> busRdata == amd_pkg::RST_ZERO
      && portAPinOe == 8'h00 && portBOption == amd_pkg::RST_ZERO)
      else $error("read data, direction or option not cleared by reset");

endmodule

// File: src/amd_pkg.sv
// Shared constants for the address map decoder: regions, register offsets, reset values
package amd_pkg;

   // Address space and region limits
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int REG_OFF_W = 7;
   localparam int INDEX_W = 11;
   localparam logic [15:0] REG_BASE = 16'h0000;
   localparam logic [15:0] REG_LAST = 16'h007f;
   localparam logic [15:0] RAM_BASE = 16'h0080;
   localparam logic [15:0] RAM_LAST = 16'h00ff;
   localparam logic [15:0] STACK_BASE = 16'h00c0;
   localparam logic [15:0] STACK_LAST = 16'h00ff;
   localparam logic [15:0] EE_BASE = 16'h1000;
   localparam logic [15:0] EE_LAST = 16'h107f;
   localparam logic [15:0] PROG_BASE = 16'hfa00;
   localparam logic [15:0] PROG_LAST = 16'hffff;
   localparam logic [15:0] VEC_BASE = 16'hffe0;

   // First program sector size per option byte code
   localparam logic [15:0] SECT0_SIZE_SMALL = 16'h0200;
   localparam logic [15:0] SECT0_SIZE_MID = 16'h0400;
   localparam logic [15:0] SECT0_SIZE_FULL = 16'h0600;
   localparam logic [1:0] SECT0_OPT_SMALL = 2'h0;
   localparam logic [1:0] SECT0_OPT_MID = 2'h1;

   // Register page offsets
   localparam logic [6:0] OFF_PA_DATA = 7'h00;
   localparam logic [6:0] OFF_PA_DIR = 7'h01;
   localparam logic [6:0] OFF_PA_OPT = 7'h02;
   localparam logic [6:0] OFF_PB_DATA = 7'h03;
   localparam logic [6:0] OFF_PB_DIR = 7'h04;
   localparam logic [6:0] OFF_PB_OPT = 7'h05;
   localparam logic [6:0] OFF_LT_CAPTURE = 7'h0c;
   localparam logic [6:0] OFF_CNT_HIGH = 7'h0e;
   localparam logic [6:0] OFF_CNT_LOW = 7'h0f;
   localparam logic [6:0] OFF_CONV_RESULT = 7'h35;

   // Plain read/write registers held by the decoder, in table order
   localparam int NUM_RW = 16;
   localparam logic [6:0] RW_OFF [NUM_RW] = '{
      7'h0b, 7'h0d, 7'h10, 7'h11, 7'h12, 7'h13, 7'h17, 7'h18,
      7'h2f, 7'h30, 7'h31, 7'h32, 7'h33, 7'h34, 7'h36, 7'h3a};
   // Bit set: register has a fixed reset value; clear: contents undefined after reset
   localparam logic [15:0] RW_DEFINED = 16'h73fe;

   // Reset values
   localparam logic [7:0] RST_PA_DATA = 8'h00;
   localparam logic [7:0] RST_PA_OPT = 8'h40;
   localparam logic [7:0] RST_PB_DATA = 8'he0;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // Port pin counts
   localparam int PA_PINS = 8;
   localparam int PB_PINS = 5;

endpackage

// File: src/amd_port.sv
// One I/O port: data, direction and option registers with pin readback
module amd_port #(
   parameter int WIDTH = 8,
   parameter logic [7:0] DATA_RST = 8'h00,
   parameter logic [7:0] OPT_RST = 8'h00
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register writes
   input wire logic wrData,
   input wire logic wrDir,
   input wire logic wrOpt,
   input wire logic [7:0] wdata,
   // Pins
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] pinOut,
   output logic [WIDTH-1:0] pinOe,
   // Register views
   output logic [7:0] option,
   output logic [7:0] readData
);

   if (WIDTH < 1 || WIDTH > 8) begin : gBadWidth
      $error("amd_port WIDTH must be 1 to 8");
   end

   logic [WIDTH-1:0] dataFf, nxtData, dirFf, nxtDir, meta1Ff, pinSyncFf;
   logic [7:0] optFf, nxtOpt;

   // Next register values from bus writes
   always_comb begin
      nxtData = wrData ? wdata[WIDTH-1:0] : dataFf;
      nxtDir = wrDir ? wdata[WIDTH-1:0] : dirFf;
      nxtOpt = wrOpt ? wdata : optFf;
   end

   // Registers; pins pass two flops before readback sees them
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dataFf <= DATA_RST[WIDTH-1:0];
         dirFf <= '0;
         optFf <= OPT_RST;
      end else begin
         dataFf <= nxtData;
         dirFf <= nxtDir;
         optFf <= nxtOpt;
      end
      meta1Ff <= pinIn;
      pinSyncFf <= meta1Ff;
   end

   // Output bits return the latch, input bits the pin; absent pins read zero
   for (genvar i = 0; i < 8; i++) begin : gBit
      if (i < WIDTH) begin : gPin
         assign readData[i] = dirFf[i] ? dataFf[i] : pinSyncFf[i];
      end else begin : gAbsent
         assign readData[i] = 1'b0;
      end
   end

   assign pinOut = dataFf;
   assign pinOe = dirFf;
   assign option = optFf;

endmodule

// File: src/amd_region_decode.sv
// Combinational region decode of a 16-bit byte address
module amd_region_decode (
   // Address and option
   input wire logic [15:0] addr,
   input wire logic [1:0] sect0Opt,
   // Region selects
   output logic selReg,
   output logic selRam,
   output logic selStack,
   output logic selEeprom,
   output logic selProg,
   output logic selSector0,
   output logic selVector,
   output logic [10:0] memIndex
);

   logic [15:0] sect0Size;
   logic [15:0] offset;

   // Option byte picks the first sector size
   always_comb begin
      unique case (sect0Opt)
         amd_pkg::SECT0_OPT_SMALL: sect0Size = amd_pkg::SECT0_SIZE_SMALL;
         amd_pkg::SECT0_OPT_MID: sect0Size = amd_pkg::SECT0_SIZE_MID;
         default: sect0Size = amd_pkg::SECT0_SIZE_FULL;
      endcase
   end

   // Region windows; gaps between regions select nothing
   always_comb begin
      selReg = (addr <= amd_pkg::REG_LAST);
      selRam = (addr >= amd_pkg::RAM_BASE) && (addr <= amd_pkg::RAM_LAST);
      selStack = (addr >= amd_pkg::STACK_BASE) && (addr <= amd_pkg::STACK_LAST);
      selEeprom = (addr >= amd_pkg::EE_BASE) && (addr <= amd_pkg::EE_LAST);
      selProg = (addr >= amd_pkg::PROG_BASE);
      selVector = (addr >= amd_pkg::VEC_BASE);
      offset = 16'h0000;
      if (selRam) begin
         offset = addr - amd_pkg::RAM_BASE;
      end else if (selEeprom) begin
         offset = addr - amd_pkg::EE_BASE;
      end else if (selProg) begin
         offset = addr - amd_pkg::PROG_BASE;
      end else begin
         offset = addr - amd_pkg::REG_BASE;
      end
      selSector0 = selProg && (offset < sect0Size);
      memIndex = offset[10:0];
   end

endmodule

// File: tb/amd_mem_model.sv
// Behavioural RAM, EEPROM and program memory standing on the decoder's memory side
module amd_mem_model (
   // Clock
   input wire logic core_clk,
   // Decoded selects and write strobe
   input wire logic memSelRam,
   input wire logic memSelEeprom,
   input wire logic memSelProg,
   input wire logic memWrite,
   input wire logic [10:0] memIndex,
   input wire logic [7:0] memWdata,
   // Read data back to the decoder
   output logic [7:0] memRdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ram [128];
   logic [7:0] ee [128];
   logic [7:0] prog [1536];
   logic [7:0] idlePat = 8'h5a;
   // Store writes into the selected array, sized as the regions are
   always @(posedge core_clk) begin
      idlePat <= idlePat + 8'h35;
      if (memWrite && memSelRam) ram[memIndex[6:0]] <= memWdata;
      if (memWrite && memSelEeprom) ee[memIndex[6:0]] <= memWdata;
      if (memWrite && memSelProg) prog[memIndex] <= memWdata;
   end
   // Unselected: a moving pattern, so a stale byte never passes for a real one
   always_comb begin
      if (memSelRam) memRdata = ram[memIndex[6:0]];
      else if (memSelEeprom) memRdata = ee[memIndex[6:0]];
      else if (memSelProg) memRdata = prog[memIndex];
      else memRdata = idlePat;
   end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the address map decoder
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CAP = 8'h3c, CHI = 8'h12, CLO = 8'h34, CRS = 8'h9a;
   localparam int LIMIT = 3000;
   typedef struct packed {logic wr; logic [15:0] a; logic [7:0] wd; logic [7:0] ex;} amd_row_s;
   typedef struct packed {logic [15:0] a; logic [5:0] s;} amd_sel_s;
   logic core_clk, rst_n, busRead, busWrite, memWrite;
   logic [15:0] busAddr;
   logic [7:0] busWdata, busRdata, memRdata, rd;
   logic memSelRam, memSelStack, memSelEeprom, memSelProg, memSelSector0, memSelVector;
   logic [10:0] memIndex;
   logic [1:0] optSector0Size;
   logic [7:0] portAPinIn, portAPinOut, portAPinOe, portAOption;
   logic [7:0] portBPinIn, portBPinOut, portBPinOe, portBOption;
   logic [7:0] ltCaptureIn, countHighIn, countLowIn, convResultIn;
   logic [amd_pkg::NUM_RW*8-1:0] rwRegs;
   logic [amd_pkg::NUM_RW-1:0] rwWriteStb;
   int errors = 0, compares = 0, cycles = 0;
   // Ordinary cases: optional write, then a read of the same byte
   amd_row_s rows [19] = '{
      '{1'b0, 16'h0002, 8'h00, 8'h40}, '{1'b0, 16'h0001, 8'h00, 8'h00}, '{1'b0, 16'h0005, 8'h00, 8'h00},
      '{1'b0, 16'h000d, 8'h00, 8'h00}, '{1'b1, 16'h0010, 8'ha5, 8'ha5}, '{1'b1, 16'h0033, 8'h5a, 8'h5a},
      '{1'b1, 16'h000c, 8'hff, CAP}, '{1'b1, 16'h000e, 8'hff, CHI}, '{1'b1, 16'h000f, 8'hff, CLO},
      '{1'b1, 16'h0035, 8'hff, CRS}, '{1'b1, 16'h0006, 8'hff, 8'h00}, '{1'b1, 16'h0037, 8'hff, 8'h00},
      '{1'b1, 16'h003b, 8'hff, 8'h00}, '{1'b1, 16'h0080, 8'h3c, 8'h3c}, '{1'b1, 16'h00c5, 8'hc3, 8'hc3},
      '{1'b1, 16'h1000, 8'h77, 8'h77}, '{1'b1, 16'h107f, 8'h11, 8'h11}, '{1'b1, 16'hfa00, 8'h88, 8'h88},
      '{1'b1, 16'h2000, 8'hff, 8'h00}};
   // Select vector {ram, stack, eeprom, prog, sector0, vector} at region edges, option code 0
   amd_sel_s sels [13] = '{
      '{16'h00bf, 6'b100000}, '{16'h00c0, 6'b110000}, '{16'h00ff, 6'b110000}, '{16'h0100, 6'b000000},
      '{16'h107f, 6'b001000}, '{16'h1080, 6'b000000}, '{16'hf9ff, 6'b000000}, '{16'hfa00, 6'b000110},
      '{16'hfbff, 6'b000110}, '{16'hfc00, 6'b000100}, '{16'hffdf, 6'b000100}, '{16'hffe0, 6'b000101},
      '{16'hffff, 6'b000101}};

   amd_decoder #(.PB_W(8)) dut (.core_clk(core_clk), .rst_n(rst_n), .busAddr(busAddr), .busRead(busRead),
      .busWrite(busWrite), .busWdata(busWdata), .busRdata(busRdata), .memSelRam(memSelRam),
      .memSelStack(memSelStack), .memSelEeprom(memSelEeprom), .memSelProg(memSelProg),
      .memSelSector0(memSelSector0), .memSelVector(memSelVector), .memWrite(memWrite), .memIndex(memIndex),
      .memRdata(memRdata), .optSector0Size(optSector0Size), .portAPinIn(portAPinIn),
      .portAPinOut(portAPinOut), .portAPinOe(portAPinOe), .portAOption(portAOption),
      .portBPinIn(portBPinIn), .portBPinOut(portBPinOut), .portBPinOe(portBPinOe),
      .portBOption(portBOption), .ltCaptureIn(ltCaptureIn), .countHighIn(countHighIn),
      .countLowIn(countLowIn), .convResultIn(convResultIn), .rwRegs(rwRegs), .rwWriteStb(rwWriteStb));

   amd_mem_model mem (.core_clk(core_clk), .memSelRam(memSelRam), .memSelEeprom(memSelEeprom),
      .memSelProg(memSelProg), .memWrite(memWrite), .memIndex(memIndex), .memWdata(busWdata),
      .memRdata(memRdata));

   // Free-running clock, 8 ns period
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Counts and verdict, reached from the main sequence or the hang guard
   task automatic end_of_test();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One write cycle; request held for exactly one taking edge
   task automatic busWr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      busAddr = a;
      busWdata = d;
      busWrite = 1'b1;
      @(posedge core_clk);
      #1;
      busWrite = 1'b0;
   endtask

   // One read cycle; data is registered at the taking edge
   task automatic busRd(input logic [15:0] a, output logic [7:0] d);
      @(posedge core_clk);
      #1;
      busAddr = a;
      busRead = 1'b1;
      @(posedge core_clk);
      #1;
      busRead = 1'b0;
      d = busRdata;
   endtask

   // Drive an address alone, for the combinational selects
   task automatic probe(input logic [15:0] a);
      @(posedge core_clk);
      #1;
      busAddr = a;
      #1;
   endtask

   // Synchronous reset held for a number of edges with a given option code
   task automatic doReset(input int n, input logic [1:0] opt);
      @(posedge core_clk);
      #1;
      rst_n = 1'b0;
      optSector0Size = opt;
      repeat (n) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
   endtask

   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         end_of_test();
      end
   end

   initial begin
      {busRead, busWrite, busAddr, busWdata} = '0;
      rst_n = 1'b0;
      optSector0Size = 2'h0;
      portAPinIn = 8'h5a;
      portBPinIn = 8'h0c;
      ltCaptureIn = CAP;
      countHighIn = CHI;
      countLowIn = CLO;
      convResultIn = CRS;
      repeat (12) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      check(portAOption, 8'h40);
      check(portBPinOut, 8'he0);
      check(portAPinOut, 8'h00);
      check(rwRegs[8+:8], 8'h00);
      check(portBOption, 8'h00);
      foreach (rows[i]) begin
         if (rows[i].wr) busWr(rows[i].a, rows[i].wd);
         busRd(rows[i].a, rd);
         check(rd, rows[i].ex);
      end
      check(rwRegs[16+:8], 8'ha5);
      check(rwRegs[96+:8], 8'h5a);
      foreach (sels[i]) begin
         probe(sels[i].a);
         check({memSelRam, memSelStack, memSelEeprom, memSelProg, memSelSector0, memSelVector},
            sels[i].s);
      end
      probe(16'h1005);
      check(memIndex, 11'h005);
      // Port readback mixes latch and pin levels bit by bit; only mapped offsets are touched
      busWr(16'h0001, 8'h0f);
      busWr(16'h0000, 8'ha5);
      busWr(16'h0004, 8'hf0);
      check(portAPinOe, 8'h0f);
      check(portBPinOe, 8'hf0);
      busRd(16'h0000, rd);
      check(rd, 8'h55);
      busRd(16'h0003, rd);
      check(rd, 8'hec);
      // Strobe rises with the write request itself; a register page write never reaches memory
      @(posedge core_clk);
      #1;
      busAddr = 16'h0033;
      busWrite = 1'b1;
      #1;
      check(rwWriteStb, 16'h1000);
      check(memWrite, 1'b0);
      @(posedge core_clk);
      #1;
      busWrite = 1'b0;
      // Mid-run reset with a new sector code restores state and moves the boundary
      doReset(3, 2'h1);
      check(portAPinOut, 8'h00);
      check(portAPinOe, 8'h00);
      check(portBPinOut, 8'he0);
      check(rwRegs[16+:8], 8'h00);
      check(rwRegs[96+:8], 8'h00);
      probe(16'hfdff);
      check(memSelSector0, 1'b1);
      probe(16'hfe00);
      check(memSelSector0, 1'b0);
      doReset(3, 2'h2);
      probe(16'hffff);
      check(memSelSector0, 1'b1);
      end_of_test();
   end
endmodule
